// ### acr_pkg.sv
// Shared constants, types and decode functions of the analog configuration register bank
`default_nettype none
package acr_pkg;
  // Bus geometry
  localparam int ACR_ADDR_W = 8;
  localparam int ACR_IDX_W = 6;
  localparam int ACR_DATA_W = 32;
  localparam int ACR_STRB_W = 4;
  // Register indexes; the byte address is four times the index
  localparam logic [5:0] ACR_IDX_EDGE_LOC = 6'h2C;
  localparam logic [5:0] ACR_IDX_SPAN_A = 6'h30;
  localparam logic [5:0] ACR_IDX_SPAN_B = 6'h32;
  localparam logic [5:0] ACR_IDX_REF_SEL = 6'h38;
  localparam logic [5:0] ACR_IDX_TS_CTRL = 6'h3B;
  // Field widths
  localparam int ACR_EDGE_W = 24;
  localparam int ACR_SPAN_W = 16;
  localparam int ACR_BYTE_W = 8;
  // Reset values
  localparam logic [23:0] ACR_EDGE_RESET = 24'h000000;
  localparam logic [15:0] ACR_SPAN_RESET = 16'hA000;
  localparam logic [7:0] ACR_REF_SEL_RESET = 8'h00;
  localparam logic [7:0] ACR_TS_CTRL_RESET = 8'h00;
  // Span code landmarks
  localparam logic [15:0] ACR_SPAN_500MV = 16'h2000;
  localparam logic [15:0] ACR_SPAN_800MV = 16'hA000;
  localparam logic [15:0] ACR_SPAN_1000MV = 16'hFFFF;
  // Field positions
  localparam int ACR_REF_SUPPLY_BIT = 0;
  localparam int ACR_TS_RX_EN_BIT = 1 - 1;
  localparam int ACR_TS_PECL_BIT = 1;
  // Bus responses
  localparam logic [1:0] ACR_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACR_RESP_SLVERR = 2'h2;

  // Settings that leave the bank for the analog core
  typedef struct packed {
    logic [15:0] spanCodeA;
    logic [15:0] spanCodeB;
    logic useSupplyReference;
    logic timestampRxEnable;
    logic timestampPeclMode;
  } acr_ctrl_type;

  // True for every mapped index
  function automatic logic acrRegHit(input logic [5:0] idx);
    return (idx == ACR_IDX_EDGE_LOC) || (idx == ACR_IDX_SPAN_A) || (idx == ACR_IDX_SPAN_B) ||
           (idx == ACR_IDX_REF_SEL) || (idx == ACR_IDX_TS_CTRL);
  endfunction

  // True for a mapped index that software may change
  function automatic logic acrRegWritable(input logic [5:0] idx);
    return acrRegHit(idx) && (idx != ACR_IDX_EDGE_LOC);
  endfunction
endpackage
`default_nettype wire

// ### acr_field_reg.sv
// Read-write register with per-byte write strobes and a fixed reset value
`timescale 1ns/100ps
`default_nettype none
module acr_field_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [WIDTH/8-1:0] wrStrb,
  output wire logic [WIDTH-1:0] value
);
  localparam int LANES = WIDTH / 8;

  // One flop group per byte lane so partial writes leave other lanes alone;
  // each lane owns its flops so every variable has a single driving process
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
      logic [7:0] lane_reg;
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          lane_reg <= RESET_VALUE[lane*8 +: 8];
        end else if (wrEn && wrStrb[lane]) begin
          lane_reg <= wrData[lane*8 +: 8];
        end
      end
      assign value[lane*8 +: 8] = lane_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// ### acr_edge_capture.sv
// Holder for the most recent reference-edge position from the measurement logic
`timescale 1ns/100ps
`default_nettype none
module acr_edge_capture (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic edgeValid,
  input wire logic [acr_pkg::ACR_EDGE_W-1:0] edgePosIn,
  output logic [acr_pkg::ACR_EDGE_W-1:0] edgeLoc
);
  import acr_pkg::*;

  // Capture on each measurement strobe; the value otherwise stands
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      edgeLoc <= ACR_EDGE_RESET;
    end else if (edgeValid) begin
      edgeLoc <= edgePosIn; // [R1]
    end
  end

  property p_edgeCaptured;
    @(posedge clk_sys) disable iff (!rst_b)
    edgeValid |=> edgeLoc == $past(edgePosIn);
  endproperty
  a_edgeCaptured: assert property (p_edgeCaptured) // [R1]
    else $error("edge position not captured on strobe");

  property p_edgeHeld;
    @(posedge clk_sys) disable iff (!rst_b)
    !edgeValid |=> $stable(edgeLoc);
  endproperty
  a_edgeHeld: assert property (p_edgeHeld) // [R1]
    else $error("edge position changed without strobe");
endmodule
`default_nettype wire

// ### acr_regs_top.sv
// AXI4-Lite register bank for converter span, reference and timestamp settings
//
// What this block does and what software using it must do
// R1 - Reports the measured 24-bit reference-edge position against the sampling clock.
// R2 - The edge-position word at index 0x2C is read-only status with no promised reset value.
// R3 - Software picks its reference delay from the reported edge position.
// R4 - Software keeps the reference delay at zero when automatic calibration is wanted.
// R5 - Channel A span code is a 16-bit read-write word at index 0x30 resetting to 0xA000.
// R6 - Channel B span code is a separate 16-bit read-write word at index 0x32, reset 0xA000.
// R7 - Span code 0x2000 means 500 mV, 0xA000 means 800 mV and 0xFFFF the 1000 mV maximum.
// R8 - Software should not program span codes below 0x2000, which are accepted but degrade.
// R9 - Bit 0 at index 0x38 selects the analog supply rail as reference instead of band-gap.
// R10 - Bit 0 at index 0x3B enables the differential timestamp receiver, reset off.
// R11 - Bit 1 at index 0x3B puts the timestamp input in low-voltage PECL mode, reset off.
// R12 - Bits 7 to 2 at index 0x3B are reserved, read-write, resetting to zero.
// R13 - Writes to the edge-position word are dropped and reads give the latest capture.
`timescale 1ns/100ps
`default_nettype none
module acr_regs_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  // Write address channel
  input wire logic [acr_pkg::ACR_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // Write data channel
  input wire logic [acr_pkg::ACR_DATA_W-1:0] wdata,
  input wire logic [acr_pkg::ACR_STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address channel
  input wire logic [acr_pkg::ACR_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // Read data channel
  output logic [acr_pkg::ACR_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Edge measurement from on-chip logic on clk_sys
  input wire logic refEdgePosValid,
  input wire logic [acr_pkg::ACR_EDGE_W-1:0] refEdgePosIn,
  // Settings to the analog core
  output acr_pkg::acr_ctrl_type analogCtrl
);
  import acr_pkg::*;

  // Write path state
  logic awHeld_reg;
  logic [ACR_IDX_W-1:0] awIndex_reg;
  logic wHeld_reg;
  logic [ACR_DATA_W-1:0] wData_reg;
  logic [ACR_STRB_W-1:0] wStrb_reg;
  logic bValid_reg;
  logic [1:0] bResp_reg;
  // Read path state
  logic rValid_reg;
  logic [ACR_DATA_W-1:0] rData_reg;
  logic [1:0] rResp_reg;
  // Helper flag for the first cycle after reset
  logic afterReset_reg;

  // Decode and datapath wires
  logic wrFire;
  logic wrHit;
  logic wrSpanA;
  logic wrSpanB;
  logic wrRefSel;
  logic wrTsCtrl;
  logic wrEdge;
  logic awTake;
  logic wTake;
  logic arTake;
  logic [ACR_IDX_W-1:0] arIndex;
  logic rdHit;
  logic [ACR_DATA_W-1:0] rdWord;
  logic [15:0] wrLow16;
  logic [7:0] wrLow8;
  logic wrBit0;
  logic wrBit1;
  logic [ACR_EDGE_W-1:0] edgeLoc;
  logic [ACR_SPAN_W-1:0] spanAReg;
  logic [ACR_SPAN_W-1:0] spanBReg;
  logic [ACR_BYTE_W-1:0] refSelReg;
  logic [ACR_BYTE_W-1:0] tsCtrlReg;

  // Handshakes: one write and one read under way at most, so ready drops while busy
  assign awready = !awHeld_reg && !bValid_reg;
  assign wready = !wHeld_reg && !bValid_reg;
  assign arready = !rValid_reg;
  assign awTake = awvalid && awready;
  assign wTake = wvalid && wready;
  assign arTake = arvalid && arready;
  assign bvalid = bValid_reg;
  assign bresp = bResp_reg;
  assign rvalid = rValid_reg;
  assign rdata = rData_reg;
  assign rresp = rResp_reg;

  // Write decode; the write lands once both address and data are held
  assign wrFire = awHeld_reg && wHeld_reg;
  assign wrHit = acrRegHit(awIndex_reg);
  assign wrSpanA = wrFire && (awIndex_reg == ACR_IDX_SPAN_A);
  assign wrSpanB = wrFire && (awIndex_reg == ACR_IDX_SPAN_B);
  assign wrRefSel = wrFire && (awIndex_reg == ACR_IDX_REF_SEL);
  assign wrTsCtrl = wrFire && (awIndex_reg == ACR_IDX_TS_CTRL);
  assign wrEdge = wrFire && (awIndex_reg == ACR_IDX_EDGE_LOC);
  assign wrLow16 = wData_reg[15:0];
  assign wrLow8 = wData_reg[7:0];
  assign wrBit0 = wData_reg[0];
  assign wrBit1 = wData_reg[1];

  // Read decode; narrow words sit in the low bits and the rest reads zero
  assign arIndex = araddr[ACR_ADDR_W-1:2];
  assign rdHit = acrRegHit(arIndex);
  assign rdWord = (arIndex == ACR_IDX_EDGE_LOC) ? {8'h00, edgeLoc} : // [R13]
                  (arIndex == ACR_IDX_SPAN_A) ? {16'h0000, spanAReg} :
                  (arIndex == ACR_IDX_SPAN_B) ? {16'h0000, spanBReg} :
                  (arIndex == ACR_IDX_REF_SEL) ? {24'h000000, refSelReg} :
                  (arIndex == ACR_IDX_TS_CTRL) ? {24'h000000, tsCtrlReg} :
                  32'h00000000;

  // Address and data are latched independently so either may arrive first
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_reg <= 1'b0;
      awIndex_reg <= 6'h00;
    end else if (awTake) begin
      awHeld_reg <= 1'b1;
      awIndex_reg <= awaddr[ACR_ADDR_W-1:2];
    end else if (wrFire) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
    end else if (wTake) begin
      wHeld_reg <= 1'b1;
      wData_reg <= wdata;
      wStrb_reg <= wstrb;
    end else if (wrFire) begin
      wHeld_reg <= 1'b0;
    end
  end

  // Write response; a write to the status word is dropped but still answered OKAY
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bValid_reg <= 1'b0;
      bResp_reg <= ACR_RESP_OKAY;
    end else if (wrFire) begin
      bValid_reg <= 1'b1;
      bResp_reg <= wrHit ? ACR_RESP_OKAY : ACR_RESP_SLVERR; // [R13]
    end else if (bready) begin
      bValid_reg <= 1'b0;
    end
  end

  // Read answer is registered one cycle after the address is taken
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rValid_reg <= 1'b0;
      rData_reg <= 32'h00000000;
      rResp_reg <= ACR_RESP_OKAY;
    end else if (arTake) begin
      rValid_reg <= 1'b1;
      rData_reg <= rdWord;
      rResp_reg <= rdHit ? ACR_RESP_OKAY : ACR_RESP_SLVERR;
    end else if (rready) begin
      rValid_reg <= 1'b0;
    end
  end

  // Helper for reset-value checks
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      afterReset_reg <= 1'b1;
    end else begin
      afterReset_reg <= 1'b0;
    end
  end

  // Edge position has no write port at all, so bus writes cannot disturb it
  acr_edge_capture u_edge (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .edgeValid(refEdgePosValid),
    .edgePosIn(refEdgePosIn),
    .edgeLoc(edgeLoc) // [R2]
  );

  // Span codes are stored as written; codes below the recommended floor are kept
  acr_field_reg #(.WIDTH(ACR_SPAN_W), .RESET_VALUE(ACR_SPAN_RESET)) u_spanA (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(wrSpanA), // [R5]
    .wrData(wrLow16),
    .wrStrb(wStrb_reg[1:0]),
    .value(spanAReg)
  );

  acr_field_reg #(.WIDTH(ACR_SPAN_W), .RESET_VALUE(ACR_SPAN_RESET)) u_spanB (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(wrSpanB), // [R6]
    .wrData(wrLow16),
    .wrStrb(wStrb_reg[1:0]),
    .value(spanBReg)
  );

  // Upper bits of the reference select are plain storage
  acr_field_reg #(.WIDTH(ACR_BYTE_W), .RESET_VALUE(ACR_REF_SEL_RESET)) u_refSel (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(wrRefSel), // [R9]
    .wrData(wrLow8),
    .wrStrb(wStrb_reg[0:0]),
    .value(refSelReg)
  );

  acr_field_reg #(.WIDTH(ACR_BYTE_W), .RESET_VALUE(ACR_TS_CTRL_RESET)) u_tsCtrl (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(wrTsCtrl), // [R10] [R11] [R12]
    .wrData(wrLow8),
    .wrStrb(wStrb_reg[0:0]),
    .value(tsCtrlReg)
  );

  // Settings to the analog core, straight from the flops
  assign analogCtrl.spanCodeA = spanAReg; // [R7]
  assign analogCtrl.spanCodeB = spanBReg; // [R7]
  assign analogCtrl.useSupplyReference = refSelReg[ACR_REF_SUPPLY_BIT]; // [R9]
  assign analogCtrl.timestampRxEnable = tsCtrlReg[ACR_TS_RX_EN_BIT]; // [R10]
  assign analogCtrl.timestampPeclMode = tsCtrlReg[ACR_TS_PECL_BIT]; // [R11]

  // Checks
  sequence s_bothTaken;
    awTake && wTake;
  endsequence

  sequence s_spanAFull;
    wrSpanA && (wStrb_reg[1:0] == 2'h3);
  endsequence

  property p_writeAnswered;
    @(posedge clk_sys) disable iff (!rst_b)
    s_bothTaken |-> ##2 bValid_reg;
  endproperty
  a_writeAnswered: assert property (p_writeAnswered)
    else $error("write not answered two cycles after both handshakes");

  property p_edgeWriteIgnored;
    @(posedge clk_sys) disable iff (!rst_b)
    (wrEdge && !refEdgePosValid) |=> ($stable(edgeLoc) && bValid_reg && bResp_reg == ACR_RESP_OKAY);
  endproperty
  a_edgeWriteIgnored: assert property (p_edgeWriteIgnored) // [R2]
    else $error("write to edge status changed it or was not answered");

  property p_edgeReadBack;
    @(posedge clk_sys) disable iff (!rst_b)
    (arTake && arIndex == ACR_IDX_EDGE_LOC) |=> (rValid_reg && rData_reg == {8'h00, $past(edgeLoc)});
  endproperty
  a_edgeReadBack: assert property (p_edgeReadBack) // [R13]
    else $error("edge status read did not return captured value");

  property p_spanAWrite;
    @(posedge clk_sys) disable iff (!rst_b)
    s_spanAFull |=> analogCtrl.spanCodeA == $past(wrLow16);
  endproperty
  a_spanAWrite: assert property (p_spanAWrite) // [R5]
    else $error("channel A span not updated by write");

  property p_spanBSeparate;
    @(posedge clk_sys) disable iff (!rst_b)
    s_spanAFull |=> $stable(analogCtrl.spanCodeB);
  endproperty
  a_spanBSeparate: assert property (p_spanBSeparate) // [R6]
    else $error("channel B span moved on channel A write");

  property p_spanDefault;
    @(posedge clk_sys) disable iff (!rst_b)
    afterReset_reg |-> (analogCtrl.spanCodeA == ACR_SPAN_800MV && analogCtrl.spanCodeB == ACR_SPAN_800MV);
  endproperty
  a_spanDefault: assert property (p_spanDefault) // [R7]
    else $error("span codes not at 800 mV after reset");

  property p_supplyRef;
    @(posedge clk_sys) disable iff (!rst_b)
    (wrRefSel && wStrb_reg[0]) |=> analogCtrl.useSupplyReference == $past(wrBit0);
  endproperty
  a_supplyRef: assert property (p_supplyRef) // [R9]
    else $error("reference source select not applied");

  property p_tsEnable;
    @(posedge clk_sys) disable iff (!rst_b)
    (wrTsCtrl && wStrb_reg[0]) |=> analogCtrl.timestampRxEnable == $past(wrBit0);
  endproperty
  a_tsEnable: assert property (p_tsEnable) // [R10]
    else $error("timestamp receiver enable not applied");

  property p_tsPecl;
    @(posedge clk_sys) disable iff (!rst_b)
    (wrTsCtrl && wStrb_reg[0]) |=> analogCtrl.timestampPeclMode == $past(wrBit1);
  endproperty
  a_tsPecl: assert property (p_tsPecl) // [R11]
    else $error("timestamp PECL mode not applied");

  property p_tsReserved;
    @(posedge clk_sys) disable iff (!rst_b)
    (wrTsCtrl && wStrb_reg[0]) |=> tsCtrlReg == $past(wrLow8);
  endproperty
  a_tsReserved: assert property (p_tsReserved) // [R12]
    else $error("timestamp control reserved bits not stored");

  property p_tsResetOff;
    @(posedge clk_sys) disable iff (!rst_b)
    afterReset_reg |-> (tsCtrlReg == ACR_TS_CTRL_RESET && !analogCtrl.timestampRxEnable);
  endproperty
  a_tsResetOff: assert property (p_tsResetOff) // [R10]
    else $error("timestamp control not zero after reset");
endmodule
`default_nettype wire

// ### acr_regs_top_tb.sv
// Self-checking testbench of the AXI4-Lite analog configuration register bank
`timescale 1ns/100ps
`default_nettype none
module acr_regs_top_tb;
  import acr_pkg::*;

  // One table row: a write, then a read back of the same word
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    logic [1:0] resp;
    logic [31:0] rd;
  } acr_row_type;

  localparam logic [7:0] ADDR_EDGE = {ACR_IDX_EDGE_LOC, 2'h0};
  localparam logic [7:0] ADDR_SPAN_A = {ACR_IDX_SPAN_A, 2'h0};
  localparam logic [7:0] ADDR_SPAN_B = {ACR_IDX_SPAN_B, 2'h0};
  localparam logic [7:0] ADDR_REF = {ACR_IDX_REF_SEL, 2'h0};
  localparam logic [7:0] ADDR_TS = {ACR_IDX_TS_CTRL, 2'h0};
  localparam logic [7:0] ADDR_HOLE = 8'h04;

  logic clk_sys;
  logic rst_b;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic refEdgePosValid;
  logic [23:0] refEdgePosIn;
  acr_ctrl_type analogCtrl;

  int errorCnt;
  int nCompared;
  acr_row_type rows [13];
  logic [1:0] resp;
  logic [31:0] rd;
  logic [15:0] sA;
  logic [15:0] sB;
  logic [7:0] rs;
  logic [7:0] ts;

  acr_regs_top dut (
    .clk_sys(clk_sys), .rst_b(rst_b),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .refEdgePosValid(refEdgePosValid), .refEdgePosIn(refEdgePosIn),
    .analogCtrl(analogCtrl)
  );

  // 20 MHz system clock
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Compare and count; case inequality so an unknown never matches
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Write; mode 0 offers both channels, 1 address first, 2 data first
  // No local limit: only the watchdog ends a wait for the slave
  task automatic axiWrite(input logic [7:0] addr, input logic [31:0] data,
                          input logic [3:0] strb, input int mode, output logic [1:0] bRes);
    bit awDone;
    bit wDone;
    awDone = 0;
    wDone = 0;
    awaddr <= addr;
    wdata <= data;
    wstrb <= strb;
    bready <= 1'h1;
    awvalid <= (mode != 2);
    wvalid <= (mode != 1);
    while (!(awDone && wDone)) begin
      @(posedge clk_sys);
      awDone = awDone || (awvalid && awready);
      wDone = wDone || (wvalid && wready);
      // Each valid is assigned once per edge to avoid a same-step double drive
      awvalid <= !awDone && (mode != 2 || wDone);
      wvalid <= !wDone && (mode != 1 || awDone);
    end
    do begin
      @(posedge clk_sys);
    end while (!bvalid);
    bRes = bresp;
    bready <= 1'h0;
    @(posedge clk_sys);
  endtask

  // Read; rready stays high until rvalid is sampled
  task automatic axiRead(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] rRes);
    araddr <= addr;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk_sys);
    end while (!arready);
    arvalid <= 1'h0;
    do begin
      @(posedge clk_sys);
    end while (!rvalid);
    data = rdata;
    rRes = rresp;
    rready <= 1'h0;
    @(posedge clk_sys);
  endtask

  // One-cycle capture pulse, then a different value with no strobe
  task automatic pulseEdge(input logic [23:0] v);
    refEdgePosIn <= v;
    refEdgePosValid <= 1'h1;
    @(posedge clk_sys);
    refEdgePosValid <= 1'h0;
    refEdgePosIn <= ~v;
    @(posedge clk_sys);
  endtask

  task automatic results();
    $display("Comparisons %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog; the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    errorCnt++;
    results();
  end

  // Main sequence
  initial begin
    errorCnt = 0;
    nCompared = 0;
    rst_b = 1'h0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, refEdgePosValid, refEdgePosIn} = '0;
    sA = ACR_SPAN_RESET;
    sB = ACR_SPAN_RESET;
    rs = 8'h00;
    ts = 8'h00;
    // Partial strobes and a dropped write sit in the middle of the table
    rows = '{
      '{ADDR_SPAN_A, 32'h0000FFFF, 4'hF, ACR_RESP_OKAY, 32'h0000FFFF},
      '{ADDR_SPAN_B, 32'h00002000, 4'h3, ACR_RESP_OKAY, 32'h00002000},
      '{ADDR_SPAN_A, 32'hFFFF5555, 4'hF, ACR_RESP_OKAY, 32'h00005555},
      '{ADDR_SPAN_A, 32'h00001200, 4'h2, ACR_RESP_OKAY, 32'h00001255},
      '{ADDR_SPAN_B, 32'h00001FFF, 4'h1, ACR_RESP_OKAY, 32'h000020FF},
      '{ADDR_REF, 32'h00000001, 4'h1, ACR_RESP_OKAY, 32'h00000001},
      '{ADDR_TS, 32'h00000001, 4'h1, ACR_RESP_OKAY, 32'h00000001},
      '{ADDR_TS, 32'h00000002, 4'h1, ACR_RESP_OKAY, 32'h00000002},
      '{ADDR_TS, 32'h000000FF, 4'h1, ACR_RESP_OKAY, 32'h000000FF},
      '{ADDR_TS, 32'h000000FC, 4'h0, ACR_RESP_OKAY, 32'h000000FF},
      '{ADDR_HOLE, 32'hDEADBEEF, 4'hF, ACR_RESP_SLVERR, 32'h00000000},
      '{ADDR_REF, 32'h000000FE, 4'h1, ACR_RESP_OKAY, 32'h000000FE},
      '{ADDR_EDGE, 32'hFFFFFFFF, 4'hF, ACR_RESP_OKAY, 32'h00000000}
    };
    repeat (8) @(posedge clk_sys);
    check("resetCtrl", analogCtrl, {ACR_SPAN_RESET, ACR_SPAN_RESET, 3'h0});
    rst_b <= 1'h1;
    @(posedge clk_sys);

    // Table of writes with read back, all three channel orders
    for (int i = 0; i < 13; i++) begin
      axiWrite(rows[i].addr, rows[i].data, rows[i].strb, i % 3, resp);
      check("bresp", resp, rows[i].resp);
      axiRead(rows[i].addr, rd, resp);
      check("rdata", rd, rows[i].rd);
      check("rresp", resp, rows[i].resp);
      if (rows[i].addr == ADDR_SPAN_A) sA = rows[i].rd[15:0];
      if (rows[i].addr == ADDR_SPAN_B) sB = rows[i].rd[15:0];
      if (rows[i].addr == ADDR_REF) rs = rows[i].rd[7:0];
      if (rows[i].addr == ADDR_TS) ts = rows[i].rd[7:0];
      check("analogCtrl", analogCtrl, {sA, sB, rs[0], ts[0], ts[1]});
    end

    // Edge capture, overwrite attempt, then the all-ones boundary
    // No reference delay choice is ever written, so automatic calibration stays usable
    pulseEdge(24'hABCDEF);
    axiRead(ADDR_EDGE, rd, resp);
    check("edgeLoc", rd, 32'h00ABCDEF);
    axiWrite(ADDR_EDGE, 32'h00123456, 4'hF, 0, resp);
    check("edgeWrResp", resp, ACR_RESP_OKAY);
    axiRead(ADDR_EDGE, rd, resp);
    check("edgeKept", rd, 32'h00ABCDEF);
    pulseEdge(24'hFFFFFF);
    axiRead(ADDR_EDGE, rd, resp);
    check("edgeMax", rd, 32'h00FFFFFF);

    // Back-to-back writes to both span words keep them separate
    axiWrite(ADDR_SPAN_A, 32'h00002000, 4'h3, 0, resp);
    axiWrite(ADDR_SPAN_B, 32'h0000FFFF, 4'h3, 0, resp);
    axiRead(ADDR_SPAN_A, rd, resp);
    check("spanA", rd, 32'h00002000);
    axiRead(ADDR_SPAN_B, rd, resp);
    check("spanB", rd, 32'h0000FFFF);

    // Reset in mid-run restores every settable word
    rst_b <= 1'h0;
    repeat (2) @(posedge clk_sys);
    check("midResetCtrl", analogCtrl, {ACR_SPAN_RESET, ACR_SPAN_RESET, 3'h0});
    rst_b <= 1'h1;
    @(posedge clk_sys);
    axiRead(ADDR_SPAN_A, rd, resp);
    check("spanAReset", rd, {16'h0000, ACR_SPAN_RESET});
    axiRead(ADDR_SPAN_B, rd, resp);
    check("spanBReset", rd, {16'h0000, ACR_SPAN_RESET});
    axiRead(ADDR_REF, rd, resp);
    check("refReset", rd, {24'h000000, ACR_REF_SEL_RESET});
    axiRead(ADDR_TS, rd, resp);
    check("tsReset", rd, {24'h000000, ACR_TS_CTRL_RESET});
    results();
  end
endmodule
`default_nettype wire
